// ==== core/iops_core.sv ====
// Purpose: peripheral-side sequencer of an i/o controller with a serial cpu port
// Assumes: serial clock and peripheral data are asynchronous to pclk
// Notes: apb slave for control and status
//
// Functional notes
// [RQ1] each function code lasts one strobe cycle, valid while strobe low
// [RQ2] idle code whenever data lines and pulses are unused
// [RQ3] register transfer codes 0000 to 0101 for load/read of A, B, C
// [RQ4] pulse, reset, mask, channel, count-zero and idle codes 0110 to 1111
// [RQ5] data-out word driven on peripheral lines while load code valid
// [RQ6] peripheral may capture the lines using the load code
// [RQ7] start, clear or aux pulse code follows in next strobe cycle
// [RQ8] no-transfer instruction sends idle code, still sends its pulse code
// [RQ9] data-in samples peripheral lines at strobe rise during read code
// [RQ10] peripheral drives its register onto lines for a read code
// [RQ11] mask-out and bus-reset codes sample peripheral lines at strobe rise
// [RQ12] peripheral gates mask or configuration data for those codes
// [RQ13] each channel word is a control transfer then a data transfer
// [RQ14] channel control samples direction on D0 and address on D1-D15
// [RQ15] internal address mode ignores sampled address bits
// [RQ16] direction 0 is channel out, 1 is channel in
// [RQ17] channel in issues channel-in code and samples the word
// [RQ18] channel out issues channel-out code and drives the cpu word
// [RQ19] count-zero code issued when word count overflows to zero
// [RQ20] sync request lowers request line on request enable, then control code
// [RQ21] channel data codes only after cpu address request
// [RQ22] transceiver direction low to transmit, else receive
// [RQ23] transmitter generates serial clock, receiver captures on it
// [RQ24] port receives four types, transmits only data
// [RQ25] short transfer one clock pulse, long transfer five
// [RQ26] first bits are type code: 11 req, 10 addr req, 01 data, 00 instr
module iops_core #(
  parameter logic [5:0] DEV_CODE_RST = 6'h10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial cpu port
  input wire logic serial_bus_clock_i,
  output logic serial_bus_clock_o,
  output logic serial_bus_clock_oe,
  input wire logic serial_line_high_i,
  output logic serial_line_high_o,
  output logic serial_line_high_oe,
  input wire logic serial_line_low_i,
  output logic serial_line_low_o,
  output logic serial_line_low_oe,
  output logic transceiver_direction,
  // peripheral port
  input wire logic [15:0] periph_data_lines_i,
  output logic [15:0] periph_data_lines_o,
  output logic periph_data_lines_oe,
  output logic [3:0] func_code,
  output logic code_strobe,
  input wire logic channel_sync_n,
  output logic channel_request_n
);

  if (DEV_CODE_RST < iops_pkg::DEV_LOW_ILLEGAL || DEV_CODE_RST == iops_pkg::DEV_ALL) begin : g_bad_dev
    $error("illegal reset device code");
  end
  if (iops_pkg::SER_HALF_CYC < 2 || iops_pkg::STB_LOW_CYC < 1) begin : g_bad_timing
    $error("clock too slow for serial or strobe timing");
  end

  typedef struct packed {
    iops_pkg::iops_state_t st;
    logic [iops_pkg::SC_W-1:0] sc;
    logic cs;
    logic [3:0] fn;
    logic [3:0] mc;
    logic [3:0] pend;
    logic pv;
    logic txn;
    logic [15:0] pdo;
    logic poe;
    logic dir;
    logic [iops_pkg::ADDR_W-1:0] addr;
    logic [15:0] wc;
    logic [15:0] word;
    logic [15:0] mask;
    logic [15:0] last_in;
    logic req_n;
    logic [2:0] ck_s;
    logic [1:0] dh_s;
    logic [1:0] dl_s;
    logic [1:0] sy_s;
    logic [15:0] pd_a;
    logic [15:0] pd_b;
    logic [3:0] rc;
    logic [1:0] rtype;
    logic [7:0] rh;
    logic [7:0] rl;
    logic rxv;
    logic [1:0] rxt;
    logic [15:0] rxw;
    logic [3:0] ts;
    logic [iops_pkg::HC_W-1:0] th;
    logic [7:0] tsh;
    logic [7:0] tsl;
    logic sco;
    logic soe;
    logic dho;
    logic dlo;
    logic xdir;
    logic en;
    logic inta;
    logic [5:0] dev;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } iops_st_t;

  iops_st_t q;
  iops_st_t n;
  logic rise;
  logic fall;
  logic cyc_end;
  logic dh;
  logic dl;
  logic [2:0] ins_op;
  logic [1:0] ins_f;
  logic [5:0] ins_dev;
  logic own;
  logic all_dev;
  logic [3:0] pcode;

  // ==========================================================================
  // next state
  always_comb begin
    n = q;
    rise = q.ck_s[1] & ~q.ck_s[2];
    fall = ~q.ck_s[1] & q.ck_s[2];
    dh = q.dh_s[1];
    dl = q.dl_s[1];
    cyc_end = (q.sc == iops_pkg::SC_LAST);
    ins_op = q.rxw[iops_pkg::INS_OP_LSB +: 3];
    ins_f = q.rxw[iops_pkg::INS_F_LSB +: 2];
    ins_dev = q.rxw[iops_pkg::INS_DEV_LSB +: 6];
    own = q.en && (ins_dev == q.dev);
    all_dev = q.en && (ins_dev == iops_pkg::DEV_ALL);
    unique case (ins_f)
      iops_pkg::PF_START: pcode = iops_pkg::FC_START;
      iops_pkg::PF_CLEAR: pcode = iops_pkg::FC_CLEAR;
      default: pcode = iops_pkg::FC_AUX;
    endcase

    // input synchronisers
    n.ck_s = {q.ck_s[1:0], serial_bus_clock_i};
    n.dh_s = {q.dh_s[0], serial_line_high_i};
    n.dl_s = {q.dl_s[0], serial_line_low_i};
    n.sy_s = {q.sy_s[0], channel_sync_n};
    n.pd_a = periph_data_lines_i;
    n.pd_b = q.pd_a;

    // free-running strobe, low phase first
    n.sc = cyc_end ? '0 : q.sc + 1'b1;
    n.cs = (n.sc >= iops_pkg::SC_LOW); // RQ1

    // ========================================================================
    // sequencer, one code per strobe cycle
    if (cyc_end) begin
      n.fn = iops_pkg::FC_IDLE; // RQ1 RQ2
      n.poe = 1'b0;
      unique case (q.st)
        iops_pkg::ST_IDLE: begin
          if (q.rxv) begin
            n.rxv = 1'b0;
            n.pv = (ins_f != iops_pkg::PF_NONE);
            n.pend = pcode;
            n.txn = 1'b0;
            if (q.rxt == iops_pkg::TY_REQ) begin
              if (q.en && !q.sy_s[1] && q.req_n) begin
                n.req_n = 1'b0; // RQ20
                n.st = iops_pkg::ST_DCTL;
                n.fn = iops_pkg::FC_CH_CTL; // RQ13
              end
            end else if (q.rxt == iops_pkg::TY_INSTR && all_dev && ins_op == iops_pkg::OP_DOB) begin
              n.st = iops_pkg::ST_CODE;
              n.fn = iops_pkg::FC_MASK; // RQ11
              n.pv = 1'b0;
            end else if (q.rxt == iops_pkg::TY_INSTR && all_dev && ins_op == iops_pkg::OP_DOA) begin
              n.st = iops_pkg::ST_CODE;
              n.fn = iops_pkg::FC_BRST; // RQ11
              n.pv = 1'b0;
            end else if (q.rxt == iops_pkg::TY_INSTR && own) begin
              case (ins_op)
                iops_pkg::OP_NIO: begin
                  n.st = iops_pkg::ST_CODE;
                  n.fn = iops_pkg::FC_IDLE; // RQ8
                end
                iops_pkg::OP_DIA: begin
                  n.st = iops_pkg::ST_CODE;
                  n.fn = iops_pkg::FC_READ_A;
                  n.txn = 1'b1;
                end
                iops_pkg::OP_DIB: begin
                  n.st = iops_pkg::ST_CODE;
                  n.fn = iops_pkg::FC_READ_B;
                  n.txn = 1'b1;
                end
                iops_pkg::OP_DIC: begin
                  n.st = iops_pkg::ST_CODE;
                  n.fn = iops_pkg::FC_READ_C;
                  n.txn = 1'b1;
                end
                iops_pkg::OP_DOA: begin
                  n.st = iops_pkg::ST_WAIT;
                  n.mc = iops_pkg::FC_LOAD_A;
                end
                iops_pkg::OP_DOB: begin
                  n.st = iops_pkg::ST_WAIT;
                  n.mc = iops_pkg::FC_LOAD_B;
                end
                iops_pkg::OP_DOC: begin
                  n.st = iops_pkg::ST_WAIT;
                  n.mc = iops_pkg::FC_LOAD_C;
                end
                default: begin
                end
              endcase
            end
          end
        end
        iops_pkg::ST_WAIT: begin
          if (q.rxv) begin
            n.rxv = 1'b0;
            if (q.rxt == iops_pkg::TY_DATA) begin
              n.st = iops_pkg::ST_CODE;
              n.fn = q.mc;
              n.word = q.rxw;
              n.pdo = q.rxw; // RQ5 RQ18
              n.poe = 1'b1; // RQ5 RQ18
            end
          end
        end
        iops_pkg::ST_CODE: begin
          if (q.fn == iops_pkg::FC_READ_A || q.fn == iops_pkg::FC_READ_B || q.fn == iops_pkg::FC_READ_C ||
              q.fn == iops_pkg::FC_CH_IN) begin
            n.word = q.pd_b; // RQ9 RQ17
            n.last_in = q.pd_b;
          end
          if (q.fn == iops_pkg::FC_MASK || q.fn == iops_pkg::FC_BRST) begin
            n.mask = q.pd_b; // RQ11
          end
          if (q.pv) begin
            n.st = iops_pkg::ST_PULSE;
            n.fn = q.pend; // RQ7 RQ8 RQ19
          end else begin
            n.st = q.txn ? iops_pkg::ST_TX : iops_pkg::ST_IDLE;
          end
        end
        iops_pkg::ST_PULSE: begin
          n.pv = 1'b0;
          n.st = q.txn ? iops_pkg::ST_TX : iops_pkg::ST_IDLE;
        end
        iops_pkg::ST_TX: begin
        end
        iops_pkg::ST_DCTL: begin
          n.dir = q.pd_b[iops_pkg::PD_DIR_BIT]; // RQ14
          if (!q.inta) begin
            n.addr = q.pd_b[iops_pkg::ADDR_W-1:0]; // RQ14 RQ15
          end
          n.st = iops_pkg::ST_DWAIT;
        end
        iops_pkg::ST_DWAIT: begin
          if (q.rxv) begin
            n.rxv = 1'b0;
            if (q.rxt == iops_pkg::TY_DCAR && !q.req_n) begin
              n.req_n = 1'b1; // RQ21
              n.wc = q.wc + 1'b1;
              n.pv = (n.wc == '0); // RQ19
              n.pend = iops_pkg::FC_WCZ;
              if (q.inta) begin
                n.addr = q.addr + 1'b1;
              end
              if (q.dir) begin
                n.st = iops_pkg::ST_CODE; // RQ16
                n.fn = iops_pkg::FC_CH_IN; // RQ17
                n.txn = 1'b1;
              end else begin
                n.st = iops_pkg::ST_WAIT; // RQ16
                n.mc = iops_pkg::FC_CH_OUT; // RQ18
                n.txn = 1'b0;
              end
            end
          end
        end
        default: n.st = iops_pkg::ST_IDLE;
      endcase
    end

    // ========================================================================
    // serial transmit of one data word
    if (q.st == iops_pkg::ST_TX) begin
      if (q.xdir) begin
        n.xdir = 1'b0; // RQ22
        n.soe = 1'b1;
        n.sco = 1'b0;
        n.th = '0;
        n.ts = '0;
        n.dho = iops_pkg::TY_DATA[1]; // RQ24 RQ26
        n.dlo = iops_pkg::TY_DATA[0];
        {n.tsh, n.tsl} = q.word;
      end else begin
        n.th = (q.th == iops_pkg::HC_LAST) ? '0 : q.th + 1'b1;
        if (q.th == iops_pkg::HC_LAST) begin
          n.sco = ~q.sco; // RQ23 RQ25
          n.ts = q.ts + 1'b1;
          if (q.ts == iops_pkg::SER_TOGGLE_LAST) begin
            n.xdir = 1'b1; // RQ22
            n.soe = 1'b0;
            n.st = iops_pkg::ST_IDLE;
          end
        end else if (q.th == '0 && q.ts != '0) begin
          n.dho = q.tsh[7];
          n.dlo = q.tsl[7];
          n.tsh = {q.tsh[6:0], 1'b0};
          n.tsl = {q.tsl[6:0], 1'b0};
        end
      end
    end

    // ========================================================================
    // serial receive, code on first rise, data on following edges
    if (q.xdir && (rise || fall)) begin
      if (q.rc == '0) begin
        if (rise) begin
          n.rtype = {dh, dl}; // RQ26
          if ({dh, dl} == iops_pkg::TY_REQ || {dh, dl} == iops_pkg::TY_DCAR) begin
            n.rxv = 1'b1; // RQ25
            n.rxt = {dh, dl};
          end else begin
            n.rc = q.rc + 1'b1;
          end
        end
      end else begin
        n.rh = {q.rh[6:0], dh}; // RQ23
        n.rl = {q.rl[6:0], dl};
        if (q.rc == iops_pkg::RX_DATA_LAST) begin
          n.rc = '0; // RQ25
          n.rxv = 1'b1; // RQ24
          n.rxt = q.rtype;
          n.rxw = {q.rh[6:0], dh, q.rl[6:0], dl};
        end else begin
          n.rc = q.rc + 1'b1;
        end
      end
    end

    // ========================================================================
    // apb slave, answer in the first access cycle
    n.rdy = psel & ~penable;
    if (psel && !penable) begin
      n.err = 1'b0;
      n.rdata = '0;
      case (paddr)
        iops_pkg::REG_CTRL: begin
          n.rdata[iops_pkg::CTRL_EN_BIT] = q.en;
          n.rdata[iops_pkg::CTRL_INTA_BIT] = q.inta;
          n.rdata[iops_pkg::CTRL_DEV_LSB +: 6] = q.dev;
        end
        iops_pkg::REG_WCNT: n.rdata[15:0] = q.wc;
        iops_pkg::REG_ADDR: n.rdata[iops_pkg::ADDR_W-1:0] = q.addr;
        iops_pkg::REG_MASK: n.rdata[15:0] = q.mask;
        iops_pkg::REG_IN: n.rdata[15:0] = q.last_in;
        iops_pkg::REG_STAT: n.rdata[iops_pkg::STAT_W-1:0] = {q.xdir, q.req_n, q.dir, q.st};
        default: n.err = 1'b1;
      endcase
    end
    if (psel && penable && q.rdy && pwrite && !q.err) begin
      case (paddr)
        iops_pkg::REG_CTRL: begin
          n.en = pwdata[iops_pkg::CTRL_EN_BIT];
          n.inta = pwdata[iops_pkg::CTRL_INTA_BIT];
          n.dev = pwdata[iops_pkg::CTRL_DEV_LSB +: 6];
        end
        iops_pkg::REG_WCNT: n.wc = pwdata[15:0];
        iops_pkg::REG_ADDR: n.addr = pwdata[iops_pkg::ADDR_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= iops_pkg::ST_IDLE;
      q.fn <= iops_pkg::FC_IDLE;
      q.req_n <= 1'b1;
      q.xdir <= 1'b1;
      q.dev <= DEV_CODE_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign serial_bus_clock_o = q.sco;
  assign serial_bus_clock_oe = q.soe;
  assign serial_line_high_o = q.dho;
  assign serial_line_high_oe = q.soe;
  assign serial_line_low_o = q.dlo;
  assign serial_line_low_oe = q.soe;
  assign transceiver_direction = q.xdir;
  assign periph_data_lines_o = q.pdo;
  assign periph_data_lines_oe = q.poe;
  assign func_code = q.fn;
  assign code_strobe = q.cs;
  assign channel_request_n = q.req_n;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge pclk iff ce);
  endclocking
  default disable iff (!presetn);

  sequence s_strobe_cycle;
    !code_strobe ##1 !code_strobe ##1 code_strobe ##1 code_strobe ##1 !code_strobe;
  endsequence
  sequence s_code_end_pulse;
    q.st == iops_pkg::ST_CODE && q.sc == iops_pkg::SC_LAST && q.pv;
  endsequence

  property p_strobe_shape;
    $fell(code_strobe) |-> s_strobe_cycle;
  endproperty
  a_strobe_shape: assert property (p_strobe_shape) else $error("strobe cycle shape wrong"); // RQ1

  property p_code_hold;
    $fell(code_strobe) |=> $stable(func_code) [*3];
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed within strobe cycle"); // RQ1

  property p_idle_code;
    $fell(code_strobe) && $past(q.st) == iops_pkg::ST_IDLE && !$past(q.rxv) |-> func_code == iops_pkg::FC_IDLE;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("non-idle code while idle"); // RQ2

  property p_load_drive;
    $fell(code_strobe) && (func_code == iops_pkg::FC_LOAD_A || func_code == iops_pkg::FC_LOAD_B ||
      func_code == iops_pkg::FC_LOAD_C || func_code == iops_pkg::FC_CH_OUT)
      |-> (periph_data_lines_oe && periph_data_lines_o == q.word) [*4];
  endproperty
  a_load_drive: assert property (p_load_drive) else $error("load word not driven"); // RQ5

  property p_pulse_next;
    s_code_end_pulse |=> q.st == iops_pkg::ST_PULSE && func_code == $past(q.pend) && !code_strobe;
  endproperty
  a_pulse_next: assert property (p_pulse_next) else $error("pulse code not in next cycle"); // RQ7

  property p_tx_dir;
    serial_bus_clock_oe != transceiver_direction;
  endproperty
  a_tx_dir: assert property (p_tx_dir) else $error("drive enable disagrees with direction"); // RQ22

  property p_tx_code;
    $fell(transceiver_direction) |-> (!serial_line_high_o && serial_line_low_o && !serial_bus_clock_o) [*4]
      ##1 serial_bus_clock_o;
  endproperty
  a_tx_code: assert property (p_tx_code) else $error("data type code not sent first"); // RQ26

  property p_dch_req;
    $fell(channel_request_n) |-> func_code == iops_pkg::FC_CH_CTL && !code_strobe;
  endproperty
  a_dch_req: assert property (p_dch_req) else $error("request fall without control code"); // RQ20

  property p_dch_order;
    func_code == iops_pkg::FC_CH_IN || func_code == iops_pkg::FC_CH_OUT |-> channel_request_n;
  endproperty
  a_dch_order: assert property (p_dch_order) else $error("channel data code before address request"); // RQ21

  property p_dctl_sample;
    q.st == iops_pkg::ST_DCTL && q.sc == iops_pkg::SC_LAST && !q.inta
      |=> q.addr == $past(q.pd_b[iops_pkg::ADDR_W-1:0]) && q.dir == $past(q.pd_b[iops_pkg::PD_DIR_BIT]);
  endproperty
  a_dctl_sample: assert property (p_dctl_sample) else $error("control word not sampled"); // RQ14

  property p_addr_keep;
    q.st == iops_pkg::ST_DCTL && q.sc == iops_pkg::SC_LAST && q.inta && !(psel && penable && pwrite)
      |=> $stable(q.addr);
  endproperty
  a_addr_keep: assert property (p_addr_keep) else $error("internal address overwritten"); // RQ15

endmodule : iops_core

// ==== core/iops_pkg.sv ====
// Purpose: shared constants for the i/o controller peripheral sequencer
// Assumes: pclk at 25 MHz
// Notes: function codes, serial type codes, register map, timing
package iops_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_NS = 40;
  localparam int STB_LOW_NS = 80;
  localparam int STB_HIGH_NS = 80;
  localparam int SER_HALF_NS = 160;
  localparam int STB_LOW_CYC = (STB_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB_PER_CYC = STB_LOW_CYC + (STB_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int SC_W = $clog2(STB_PER_CYC);
  localparam int HC_W = $clog2(SER_HALF_CYC);
  localparam logic [SC_W-1:0] SC_LOW = SC_W'(STB_LOW_CYC);
  localparam logic [SC_W-1:0] SC_LAST = SC_W'(STB_PER_CYC - 1);
  localparam logic [HC_W-1:0] HC_LAST = HC_W'(SER_HALF_CYC - 1);
  localparam logic [3:0] SER_TOGGLE_LAST = 4'h9;
  localparam logic [3:0] RX_DATA_LAST = 4'h8;

  // ==========================================================================
  // function codes
  localparam logic [3:0] FC_LOAD_A = 4'h0; // RQ3
  localparam logic [3:0] FC_READ_A = 4'h1; // RQ3
  localparam logic [3:0] FC_LOAD_B = 4'h2; // RQ3
  localparam logic [3:0] FC_READ_B = 4'h3; // RQ3
  localparam logic [3:0] FC_LOAD_C = 4'h4; // RQ3
  localparam logic [3:0] FC_READ_C = 4'h5; // RQ3
  localparam logic [3:0] FC_START = 4'h6; // RQ4
  localparam logic [3:0] FC_CLEAR = 4'h7; // RQ4
  localparam logic [3:0] FC_AUX = 4'h8; // RQ4
  localparam logic [3:0] FC_BRST = 4'h9; // RQ4
  localparam logic [3:0] FC_MASK = 4'hA; // RQ4
  localparam logic [3:0] FC_CH_CTL = 4'hB; // RQ4
  localparam logic [3:0] FC_CH_IN = 4'hC; // RQ4
  localparam logic [3:0] FC_CH_OUT = 4'hD; // RQ4
  localparam logic [3:0] FC_WCZ = 4'hE; // RQ4
  localparam logic [3:0] FC_IDLE = 4'hF; // RQ4

  // ==========================================================================
  // serial type codes, first bit high line then low line
  localparam logic [1:0] TY_REQ = 2'h3;
  localparam logic [1:0] TY_DCAR = 2'h2;
  localparam logic [1:0] TY_DATA = 2'h1;
  localparam logic [1:0] TY_INSTR = 2'h0;

  // ==========================================================================
  // instruction word fields
  localparam int INS_OP_LSB = 8;
  localparam int INS_F_LSB = 6;
  localparam int INS_DEV_LSB = 0;
  localparam logic [2:0] OP_NIO = 3'h0;
  localparam logic [2:0] OP_DIA = 3'h1;
  localparam logic [2:0] OP_DOA = 3'h2;
  localparam logic [2:0] OP_DIB = 3'h3;
  localparam logic [2:0] OP_DOB = 3'h4;
  localparam logic [2:0] OP_DIC = 3'h5;
  localparam logic [2:0] OP_DOC = 3'h6;
  localparam logic [1:0] PF_NONE = 2'h0;
  localparam logic [1:0] PF_START = 2'h1;
  localparam logic [1:0] PF_CLEAR = 2'h2;
  localparam logic [5:0] DEV_ALL = 6'h3F;
  localparam logic [5:0] DEV_LOW_ILLEGAL = 6'h04;
  localparam int PD_DIR_BIT = 15;
  localparam int ADDR_W = 15;

  // ==========================================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WCNT = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam logic [7:0] REG_IN = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_INTA_BIT = 1;
  localparam int CTRL_DEV_LSB = 8;
  localparam int STAT_W = 10;

  // ==========================================================================
  // sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WAIT = 7'h02,
    ST_CODE = 7'h04,
    ST_PULSE = 7'h08,
    ST_TX = 7'h10,
    ST_DCTL = 7'h20,
    ST_DWAIT = 7'h40
  } iops_state_t;

endpackage : iops_pkg

// ==== sim/iops_periph.sv ====
// Purpose: peripheral logic model behind the function-code port
// Assumes: codes change at strobe fall
// Notes: drives a code-tagged word for gate-in codes, else the inverse of the last one
module iops_periph (
  // peripheral port
  input wire logic [3:0] func_code,
  input wire logic code_strobe,
  input wire logic [15:0] dev_o,
  input wire logic dch_out,
  output logic [15:0] dev_i,
  // observation
  output logic [15:0] load_word_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last_q = 16'h0000;
  logic drv;
  // channel control word carries D0 = 1 (channel in), dch_out clears it (channel out)
  assign drv = func_code inside {4'h1, 4'h3, 4'h5, 4'h9, 4'hA, 4'hB, 4'hC};
  assign dev_i = drv ? {func_code ^ {dch_out, 3'h0}, 12'h5A3} : ~last_q;
  always @(dev_i) if (drv) last_q <= dev_i;
  always @(posedge code_strobe) begin
    if (func_code inside {4'h0, 4'h2, 4'h4, 4'hD}) load_word_q <= dev_o;
  end
endmodule : iops_periph

// ==== sim/iops_core_bench.sv ====
// Purpose: self-checking bench of the sequencer
// Assumes: cpu serial clock 320 ns, idle low between frames
// Notes: every strobe cycle code is logged except an idle code after an idle code, a burst ends at the first idle code
module iops_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sck = 1'b0, shi = 1'b0, slo = 1'b0, sync_n = 1'b1, dch_out = 1'b0;
  logic ck_o, ck_oe, hi_o, hi_oe, lo_o, lo_oe, xdir, strobe, req_n, pd_oe;
  logic [15:0] pd_i, pd_o, ld_w;
  logic [3:0] fc, lastf = 4'hF;
  logic [9:0] th, tl;
  logic [3:0] cq[$];
  int err_total = 0, tests_run = 0, cyc = 0;
  iops_core iops_core_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_bus_clock_i(ck_oe ? ck_o : sck), .serial_bus_clock_o(ck_o), .serial_bus_clock_oe(ck_oe),
    .serial_line_high_i(hi_oe ? hi_o : shi), .serial_line_high_o(hi_o), .serial_line_high_oe(hi_oe),
    .serial_line_low_i(lo_oe ? lo_o : slo), .serial_line_low_o(lo_o), .serial_line_low_oe(lo_oe),
    .transceiver_direction(xdir), .periph_data_lines_i(pd_i), .periph_data_lines_o(pd_o),
    .periph_data_lines_oe(pd_oe), .func_code(fc), .code_strobe(strobe), .channel_sync_n(sync_n),
    .channel_request_n(req_n));
  iops_periph iops_periph_i (.func_code(fc), .code_strobe(strobe), .dev_o(pd_oe ? pd_o : ~pd_o),
    .dch_out(dch_out), .dev_i(pd_i), .load_word_q(ld_w));
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      report_and_stop();
    end
  end
  always @(posedge strobe) begin
    if (fc !== 4'hF || lastf !== 4'hF) cq.push_back(fc);
    lastf = fc;
  end
  always @(ck_o) if (ck_oe) begin
    th <= {th[8:0], hi_o};
    tl <= {tl[8:0], lo_o};
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task ser(input logic [1:0] ty, input logic [15:0] w, input bit lng);
    shi <= ty[1];
    slo <= ty[0];
    repeat (2) @(posedge pclk);
    sck <= 1'b1;
    if (lng) for (int i = 7; i >= 0; i--) begin
      repeat (2) @(posedge pclk);
      {shi, slo} <= {w[8+i], w[i]};
      repeat (2) @(posedge pclk);
      sck <= ~sck;
    end
    repeat (4) @(posedge pclk);
    sck <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : ser
  task seq(input int n, input logic [19:0] e);
    logic [19:0] g;
    g = 20'h0;
    for (int k = 0; k < 600 && cq.size() < n; k++) @(posedge pclk);
    for (int k = 0; k < n; k++) g[19-4*k -: 4] = cq[k];
    chk(g, e);
    cq.delete();
    $display("test done at %0t", $time);
  endtask : seq
  task wtx(input logic [15:0] w);
    do @(posedge pclk); while (xdir !== 1'b0);
    do @(posedge pclk); while (xdir !== 1'b1);
    chk({th[8], tl[8], th[7:0], tl[7:0]}, {2'h1, w});
  endtask : wtx
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({fc, req_n, xdir}, 6'h3F);
    apb(1'b1, iops_pkg::REG_CTRL, 32'h1001);
    apb(1'b0, 8'h18, 32'h0);
    chk(pslverr, 1'b1);
    for (int i = 0; i < 3; i++) begin
      ser(iops_pkg::TY_INSTR, {5'h0C, 3'(2*i+2), 2'(i+1), 6'h10}, 1'b1);
      ser(iops_pkg::TY_DATA, 16'hC3A5 ^ 16'(i), 1'b1);
      seq(3, {4'(2*i), 4'(6+i), 12'hF00});
      chk(ld_w, 16'hC3A5 ^ 16'(i));
    end
    ser(iops_pkg::TY_INSTR, 16'h60D0, 1'b1);
    seq(2, 20'h8F000);
    ser(iops_pkg::TY_INSTR, 16'h6390, 1'b1);
    seq(3, 20'h37F00);
    wtx(16'h35A3);
    for (int j = 0; j < 2; j++) begin
      ser(iops_pkg::TY_INSTR, {5'h0C, j ? 3'h2 : 3'h4, 8'h3F}, 1'b1);
      ser(iops_pkg::TY_DATA, 16'h1234, 1'b1);
      seq(2, {j ? 4'h9 : 4'hA, 16'hF000});
      apb(1'b0, iops_pkg::REG_MASK, 32'h0);
      chk(rd, {16'h0, j ? 4'h9 : 4'hA, 12'h5A3});
    end
    apb(1'b1, iops_pkg::REG_WCNT, 32'hFFFF);
    sync_n <= 1'b0;
    ser(iops_pkg::TY_REQ, 16'h0, 1'b0);
    seq(2, 20'hBF000);
    chk(req_n, 1'b0);
    sync_n <= 1'b1;
    apb(1'b0, iops_pkg::REG_ADDR, 32'h0);
    chk(rd, 32'h35A3);
    ser(iops_pkg::TY_DCAR, 16'h0, 1'b0);
    seq(3, 20'hCEF00);
    chk(req_n, 1'b1);
    wtx(16'hC5A3);
    apb(1'b1, iops_pkg::REG_CTRL, 32'h1003);
    apb(1'b1, iops_pkg::REG_ADDR, 32'h0100);
    sync_n <= 1'b0;
    dch_out <= 1'b1;
    ser(iops_pkg::TY_REQ, 16'h0, 1'b0);
    seq(2, 20'hBF000);
    sync_n <= 1'b1;
    apb(1'b0, iops_pkg::REG_ADDR, 32'h0);
    chk(rd, 32'h0100);
    ser(iops_pkg::TY_DCAR, 16'h0, 1'b0);
    ser(iops_pkg::TY_DATA, 16'h5AC3, 1'b1);
    seq(2, 20'hDF000);
    chk(ld_w, 16'h5AC3);
    apb(1'b0, iops_pkg::REG_ADDR, 32'h0);
    chk(rd, 32'h0101);
    report_and_stop();
  end
endmodule : iops_core_bench
